//--- rtl/scdiv_pkg.sv
// Constants shared by the synchronous clock divider
package scdiv_pkg;
    localparam int SCDIV_STAGES = 3;
    localparam int SCDIV_SYNC_LEN = 3;
    localparam logic [1:0] SCDIV_SKIP_HIGH = 2'h1;
    localparam logic [1:0] SCDIV_SKIP_LOW = 2'h2;
    localparam logic [1:0] SCDIV_SKIP_NONE = 2'h0;
    localparam logic [2:0] SCDIV_SYNC_RST = 3'h0;
    localparam logic SCDIV_FREEZE_RST = 1'b0;
    localparam logic [2:0] SCDIV_CNT_RST = 3'h0;
    localparam int SCDIV_IN_SRC = 0;
    localparam int SCDIV_IN_CLR = 1;
    localparam int SCDIV_IN_HOLD = 2;
    localparam int SCDIV_IN_NUM = 3;
endpackage

//--- rtl/scdiv_top.sv
// Synchronous divide-by-2/4/8 divider with clear and glitch-free hold
`timescale 1ns/10ps
module scdiv_top import scdiv_pkg::*; #(
    parameter int STAGES = SCDIV_STAGES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Pins from the source side
    input wire logic src_clk,
    input wire logic divider_clear,
    input wire logic hold,
    // Divided outputs
    output logic half_rate_out,
    output logic quarter_rate_out,
    output logic eighth_rate_out
);
    if (STAGES != SCDIV_STAGES) begin : g_bad_stages
        $error("scdiv_top serves exactly three divider stages");
    end

    logic [SCDIV_IN_NUM-1:0] pin_in;
    logic [SCDIV_IN_NUM-1:0] pin_agree;
    logic [SCDIV_IN_NUM-1:0] pin_new;
    logic [SCDIV_IN_NUM-1:0] flt_r;
    logic [SCDIV_IN_NUM-1:0] flt_nxt;
    logic [STAGES-1:0] cnt_r;
    logic [STAGES-1:0] cnt_nxt;
    logic [STAGES-1:0] carry;
    logic [1:0] skip_r;
    logic [1:0] skip_nxt;
    logic freeze_r;
    logic freeze_nxt;
    logic src_rise;
    logic src_fall;
    logic clr_lvl;
    logic clr_release;
    logic advance;

    assign pin_in = {hold, divider_clear, src_clk};

    // Three-stage synchronisers with agreement filter
    for (genvar i = 0; i < SCDIV_IN_NUM; i++) begin : g_sync
        logic [SCDIV_SYNC_LEN-1:0] sh_r;
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                sh_r <= SCDIV_SYNC_RST;
            end else begin
                sh_r <= {sh_r[SCDIV_SYNC_LEN-2:0], pin_in[i]};
            end
        end
        assign pin_agree[i] = (sh_r[1] == sh_r[2]);
        assign pin_new[i] = sh_r[1];
        assign flt_nxt[i] = pin_agree[i] ? pin_new[i] : flt_r[i];
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flt_r <= SCDIV_SYNC_RST;
        end else begin
            flt_r <= flt_nxt;
        end
    end

    // Edge and level decode
    assign src_rise = !flt_r[SCDIV_IN_SRC] && flt_nxt[SCDIV_IN_SRC];
    assign src_fall = flt_r[SCDIV_IN_SRC] && !flt_nxt[SCDIV_IN_SRC];
    assign clr_lvl = flt_nxt[SCDIV_IN_CLR];
    assign clr_release = flt_r[SCDIV_IN_CLR] && !clr_lvl;

    // Enable flop sampled on falling source edges
    assign freeze_nxt = src_fall ? flt_nxt[SCDIV_IN_HOLD] : freeze_r;

    // Rising edges swallowed after clear release
    assign skip_nxt = clr_lvl ? SCDIV_SKIP_NONE :
        clr_release ? (flt_r[SCDIV_IN_SRC] ? SCDIV_SKIP_HIGH : SCDIV_SKIP_LOW) :
        (src_rise && skip_r != SCDIV_SKIP_NONE) ? skip_r - 2'h1 : skip_r;

    assign advance = src_rise && !freeze_r && !clr_lvl && !clr_release
        && skip_r == SCDIV_SKIP_NONE;

    // Ripple-free synchronous count, one toggle term per stage
    for (genvar b = 0; b < STAGES; b++) begin : g_stage
        if (b == 0) begin : g_lsb
            assign carry[b] = advance;
        end else begin : g_upper
            assign carry[b] = carry[b-1] && cnt_r[b-1];
        end
        assign cnt_nxt[b] = clr_lvl ? 1'b0 : cnt_r[b] ^ carry[b];
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_r <= SCDIV_CNT_RST;
            skip_r <= SCDIV_SKIP_NONE;
            freeze_r <= SCDIV_FREEZE_RST;
        end else begin
            cnt_r <= cnt_nxt;
            skip_r <= skip_nxt;
            freeze_r <= freeze_nxt;
        end
    end

    assign half_rate_out = cnt_r[0];
    assign quarter_rate_out = cnt_r[1];
    assign eighth_rate_out = cnt_r[2];

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_clear_zero;
        clr_lvl |=> cnt_r == '0;
    endproperty
    a_clear_zero: assert property (p_clear_zero) else $error("clear did not zero");

    property p_release_high;
        clr_release && flt_r[SCDIV_IN_SRC] |=> skip_r == SCDIV_SKIP_HIGH;
    endproperty
    a_release_high: assert property (p_release_high) else $error("high skip wrong");

    property p_release_low;
        clr_release && !flt_r[SCDIV_IN_SRC] |=> skip_r == SCDIV_SKIP_LOW;
    endproperty
    a_release_low: assert property (p_release_low) else $error("low skip wrong");

    property p_skip_holds;
        src_rise && skip_r != SCDIV_SKIP_NONE && !clr_lvl
            |=> $stable(cnt_r) && skip_r == $past(skip_r) - 2'h1;
    endproperty
    a_skip_holds: assert property (p_skip_holds) else $error("skipped edge counted");

    property p_freeze_on_fall;
        src_fall && flt_nxt[SCDIV_IN_HOLD] |=> freeze_r;
    endproperty
    a_freeze_on_fall: assert property (p_freeze_on_fall) else $error("hold not taken");

    property p_frozen_stable;
        freeze_r && !clr_lvl |=> $stable(cnt_r);
    endproperty
    a_frozen_stable: assert property (p_frozen_stable) else $error("frozen count moved");

    property p_unfreeze;
        freeze_r && !src_fall |=> freeze_r;
    endproperty
    a_unfreeze: assert property (p_unfreeze) else $error("unfreeze off a fall");

    property p_next_count;
        advance |=> cnt_r == $past(cnt_r) + 3'h1;
    endproperty
    a_next_count: assert property (p_next_count) else $error("count not stepped");

    property p_phase;
        $changed(quarter_rate_out) && !$past(clr_lvl) |-> $fell(half_rate_out);
    endproperty
    a_phase: assert property (p_phase) else $error("quarter out of phase");

    property p_phase8;
        $changed(eighth_rate_out) && !$past(clr_lvl) |-> $fell(quarter_rate_out);
    endproperty
    a_phase8: assert property (p_phase8) else $error("eighth out of phase");

    property p_idle_stable;
        !src_rise && !clr_lvl |=> $stable(cnt_r);
    endproperty
    a_idle_stable: assert property (p_idle_stable) else $error("count moved off a rise");

    property p_skip_blocks;
        skip_r != SCDIV_SKIP_NONE && !clr_lvl |=> $stable(cnt_r);
    endproperty
    a_skip_blocks: assert property (p_skip_blocks) else $error("swallowed rise counted");

    property p_release_zero;
        clr_release |=> cnt_r == SCDIV_CNT_RST;
    endproperty
    a_release_zero: assert property (p_release_zero) else $error("count not zero on release");

    property p_unfreeze_low;
        src_fall && !flt_nxt[SCDIV_IN_HOLD] |=> !freeze_r;
    endproperty
    a_unfreeze_low: assert property (p_unfreeze_low) else $error("freeze kept after fall");

    property p_freeze_wait;
        !freeze_r && !src_fall |=> !freeze_r;
    endproperty
    a_freeze_wait: assert property (p_freeze_wait) else $error("freeze off a fall");

    property p_quarter_follow;
        $fell(half_rate_out) && !$past(clr_lvl) |-> $changed(quarter_rate_out);
    endproperty
    a_quarter_follow: assert property (p_quarter_follow) else $error("quarter missed carry");

    property p_eighth_follow;
        $fell(quarter_rate_out) && !$past(clr_lvl) |-> $changed(eighth_rate_out);
    endproperty
    a_eighth_follow: assert property (p_eighth_follow) else $error("eighth missed carry");

    property p_skip_wait;
        skip_r != SCDIV_SKIP_NONE && !src_rise && !clr_lvl |=> $stable(skip_r);
    endproperty
    a_skip_wait: assert property (p_skip_wait) else $error("skip moved off a rise");

    property p_clear_skip;
        clr_lvl |=> skip_r == SCDIV_SKIP_NONE;
    endproperty
    a_clear_skip: assert property (p_clear_skip) else $error("skip kept under clear");

    property p_half_step;
        advance |=> $changed(half_rate_out);
    endproperty
    a_half_step: assert property (p_half_step) else $error("half did not toggle");

    property p_count_only_up;
        $changed(cnt_r) && !$past(clr_lvl) |-> cnt_r == $past(cnt_r) + 3'h1;
    endproperty
    a_count_only_up: assert property (p_count_only_up) else $error("count jumped");
endmodule // scdiv_top

//--- tb/scdiv_src.sv
// Source clock model, stands low while stopped
`timescale 1ns/10ps
module scdiv_src (
    // Clock and control
    input wire logic clk,
    input wire logic run,
    input wire logic [3:0] half,
    // Source clock pin
    output logic src_clk
);
    logic [3:0] cnt_r;
    always_ff @(posedge clk) begin
        if (!run) begin
            cnt_r <= 4'h0;
            src_clk <= 1'b0;
        end else if (cnt_r >= half - 4'h1) begin
            cnt_r <= 4'h0;
            src_clk <= !src_clk;
        end else begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
endmodule // scdiv_src

//--- tb/testbench.sv
// Self-checking bench for the clock divider
`timescale 1ns/10ps
module testbench;
    logic clk, sys_rst, divider_clear, hold, run, src_clk, prev_src, prev_clr, frz;
    logic half_rate_out, quarter_rate_out, eighth_rate_out;
    logic [3:0] half;
    logic [2:0] dir [14] = '{3'h5, 3'h0, 3'h0, 3'h5, 3'h1, 3'h0, 3'h0, 3'h2, 3'h3, 3'h3,
        3'h1, 3'h0, 3'h5, 3'h0};
    int cnt, skip, failures, n_checks, cycles;
    event ev_rise, ev_fall;
    scdiv_top dut_u (.clk(clk), .sys_rst(sys_rst), .src_clk(src_clk),
        .divider_clear(divider_clear), .hold(hold), .half_rate_out(half_rate_out),
        .quarter_rate_out(quarter_rate_out), .eighth_rate_out(eighth_rate_out));
    scdiv_src src_u (.clk(clk), .run(run), .half(half), .src_clk(src_clk));
    initial begin
        clk = 1'b0;
        forever #4 clk = !clk;
    end
    task automatic end_sim();
        if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Reference count, updated at rising source edges and checked at falling ones
    always @(posedge clk) begin
        cycles++;
        if (cycles > 4000) begin
            failures++;
            $display("CHECK FAILED %0t run timed out", $time);
            end_sim();
        end
        prev_src <= src_clk;
        prev_clr <= divider_clear;
        if (sys_rst) begin
            cnt = 0;
            frz = 1'b0;
        end else begin
            if (prev_clr && !divider_clear) skip = src_clk ? 1 : 2;
            if (src_clk && !prev_src) begin
                if (divider_clear) cnt = 0;
                else if (skip > 0) skip--;
                else if (!frz) cnt = (cnt + 1) % 8;
                -> ev_rise;
            end
            if (!src_clk && prev_src) begin
                n_checks++;
                if ({eighth_rate_out, quarter_rate_out, half_rate_out} !== 3'(cnt)) begin
                    failures++;
                    $display("CHECK FAILED %0t outputs differ from count", $time);
                end
                frz = hold;
                -> ev_fall;
            end
        end
    end
    // One control step, mid-phase after a source edge
    task automatic step(input logic c, input logic h, input logic ph);
        if (ph) @ev_fall;
        else @ev_rise;
        repeat (4) @(posedge clk);
        divider_clear <= c;
        hold <= h;
        half <= 4'(8 + $urandom_range(3));
    endtask
    initial begin
        void'($urandom(32'he8e33b7c));
        {sys_rst, divider_clear, hold, run, half} = {4'hc, 4'h8};
        {failures, n_checks, cycles, skip} = '0;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        run <= 1'b1;
        foreach (dir[i]) step(dir[i][2], dir[i][1], dir[i][0]);
        repeat (10) step(1'b0, 1'b0, 1'b0);
        repeat (40) begin
            step($urandom_range(3) == 0, 1'($urandom), 1'b1);
            step(1'b0, 1'($urandom), 1'($urandom));
        end
        end_sim();
    end
endmodule // testbench
